// [rtl/tcce_top.sv]
// Three-channel capture edge detector with register file on Avalon-MM
module tcce_top #(
   parameter int FILT_CYCLES = tcce_pkg::TCCE_FILT_CYCLES
) (
   input  wire logic                            clock,
   input  wire logic                            sys_rst,
   input  wire logic [tcce_pkg::TCCE_ADDR_W-1:0] avs_address,
   input  wire logic                            avs_read,
   input  wire logic                            avs_write,
   input  wire logic [tcce_pkg::TCCE_DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]                      avs_byteenable,
   output logic [tcce_pkg::TCCE_DATA_W-1:0]      avs_readdata,
   output logic                                 avs_waitrequest,
   output logic [1:0]                           avs_response,
   input  wire logic [tcce_pkg::TCCE_CHANNELS-1:0] capture_in,
   output logic [tcce_pkg::TCCE_CHANNELS-1:0]      capture_event,
   output logic                                 irq
);
   import tcce_pkg::*;
   localparam int N = TCCE_CHANNELS;

   function automatic logic hit(input logic [TCCE_ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a[TCCE_ADDR_W-1:2] == idx[TCCE_ADDR_W-3:0]) && (a[1:0] == 2'h0);
   endfunction

   // Registers
   logic [N-1:0]          enable_r;
   logic [N-1:0]          flag_r;
   logic [N-1:0]          flag_nxt;
   logic [2*N-1:0]        edge_sel_r;
   logic [N-1:0]          filt_on_r;
   logic [N-1:0]          irq_status_r;
   logic [N-1:0]          irq_status_nxt;
   logic [N-1:0]          irq_mask_r;
   logic [TCCE_DATA_W-1:0] rdata_r;
   logic                  resp_err_r;
   tcce_bus_type          bus_state_r;

   // Bus decode
   wire sel_enflag = hit(avs_address, TCCE_IDX_ENFLAG);
   wire sel_edge   = hit(avs_address, TCCE_IDX_EDGE);
   wire sel_filt   = hit(avs_address, TCCE_IDX_FILT);
   wire sel_irq_st = hit(avs_address, TCCE_IDX_IRQ_ST);
   wire sel_irq_mk = hit(avs_address, TCCE_IDX_IRQ_MK);
   wire mapped     = sel_enflag | sel_edge | sel_filt | sel_irq_st | sel_irq_mk;
   wire req        = avs_read | avs_write;
   // One wait state: request taken in idle, answered next cycle
   wire accept     = req && (bus_state_r == TCCE_IDLE);
   wire wr_low     = accept && avs_write && avs_byteenable[0];
   wire [7:0] wbyte = avs_writedata[7:0];

   wire [7:0] enflag_view = {1'b0, enable_r, 1'b0, flag_r};
   wire [7:0] edge_view   = {2'b00, edge_sel_r};
   wire [7:0] filt_view   = {1'b0, filt_on_r, 4'h0};
   wire [7:0] irq_st_view = {{(8-N){1'b0}}, irq_status_r};
   wire [7:0] irq_mk_view = {{(8-N){1'b0}}, irq_mask_r};
   wire [7:0] read_byte   = sel_enflag ? (enflag_view & TCCE_ENFLAG_MASK) :
                            sel_edge   ? (edge_view & TCCE_EDGE_MASK) :
                            sel_filt   ? (filt_view & TCCE_FILT_MASK) :
                            sel_irq_st ? irq_st_view :
                            sel_irq_mk ? irq_mk_view : TCCE_RST_BYTE;

   // Input path per channel
   logic [N-1:0] sync1_r;
   logic [N-1:0] sync2_r;
   logic [N-1:0] filtered;
   logic [N-1:0] chosen;
   logic [N-1:0] prev_r;
   logic [N-1:0] edge_hit;
   logic [N-1:0] event_r;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_chan
         wire [1:0] sel  = edge_sel_r[g*TCCE_SEL_W +: TCCE_SEL_W];
         wire       rise = chosen[g] & ~prev_r[g];
         wire       fall = ~chosen[g] & prev_r[g];
         tcce_filter #(.CYCLES(FILT_CYCLES)) u_filt (
            .clock     (clock),
            .sys_rst   (sys_rst),
            .sample_in (sync2_r[g]),
            .level_out (filtered[g])
         );
         assign chosen[g] = filt_on_r[g] ? filtered[g] : sync2_r[g];
         // Reserved code 11 detects nothing
         assign edge_hit[g] = enable_r[g] & (
                              (sel == TCCE_SEL_FALL & fall) |
                              (sel == TCCE_SEL_RISE & rise) |
                              (sel == TCCE_SEL_BOTH & (rise | fall)));
      end
   endgenerate

   // Set wins over a software clear in the same cycle
   wire [N-1:0] flag_wr_clr = (wr_low && sel_enflag) ?
                              ~wbyte[TCCE_FLAG_LSB +: N] : '0;
   wire [N-1:0] flag_wr_set = (wr_low && sel_enflag) ?
                              wbyte[TCCE_FLAG_LSB +: N] : '0;
   assign flag_nxt = edge_hit | flag_wr_set | (flag_r & ~flag_wr_clr);
   wire [N-1:0] st_clr = (wr_low && sel_irq_st) ? wbyte[N-1:0] : '0;
   assign irq_status_nxt = edge_hit | (irq_status_r & ~st_clr);

   assign capture_event   = event_r;
   assign irq             = |(irq_status_r & irq_mask_r);
   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = req && (bus_state_r == TCCE_IDLE);
   assign avs_response    = resp_err_r ? 2'h2 : 2'h0;

   // Input synchroniser and edge history
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
         event_r <= '0;
      end else begin
         sync1_r <= capture_in;
         sync2_r <= sync1_r;
         prev_r  <= chosen;
         event_r <= edge_hit;
      end
   end

   // Control registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         enable_r   <= '0;
         edge_sel_r <= '0;
         filt_on_r  <= '0;
         irq_mask_r <= '0;
      end else if (wr_low) begin
         if (sel_enflag) enable_r <= wbyte[TCCE_EN_LSB +: N];
         if (sel_edge) edge_sel_r <= wbyte[2*N-1:0];
         if (sel_filt) filt_on_r <= wbyte[TCCE_FILT_LSB +: N];
         if (sel_irq_mk) irq_mask_r <= wbyte[N-1:0];
      end
   end

   // Flags and interrupt status
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flag_r       <= '0;
         irq_status_r <= '0;
      end else begin
         flag_r       <= flag_nxt;
         irq_status_r <= irq_status_nxt;
      end
   end

   // Bus answer
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bus_state_r <= TCCE_IDLE;
         rdata_r     <= '0;
         resp_err_r  <= 1'b0;
      end else begin
         case (bus_state_r)
            TCCE_IDLE: begin
               if (accept) begin
                  bus_state_r <= TCCE_ACK;
                  rdata_r     <= mapped ? {24'h000000, read_byte} : TCCE_BAD_READ;
                  resp_err_r  <= ~mapped;
               end
            end
            TCCE_ACK: begin
               bus_state_r <= TCCE_IDLE;
            end
            default: begin
               bus_state_r <= TCCE_IDLE;
            end
         endcase
      end
   end
endmodule

// [rtl/tcce_pkg.sv]
// Constants and types of the three-channel capture edge front end
package tcce_pkg;
   localparam int   TCCE_CHANNELS      = 3;
   localparam int   TCCE_ADDR_W        = 8;
   localparam int   TCCE_DATA_W        = 32;
   localparam int   TCCE_REG_W         = 8;
   // Register indices as printed; byte address is four times the low six bits of the index
   localparam logic [7:0] TCCE_IDX_ENFLAG = 8'h92;
   localparam logic [7:0] TCCE_IDX_EDGE   = 8'h93;
   localparam logic [7:0] TCCE_IDX_FILT   = 8'h94;
   localparam logic [7:0] TCCE_IDX_IRQ_ST = 8'h98;
   localparam logic [7:0] TCCE_IDX_IRQ_MK = 8'h99;
   // Field positions
   localparam int   TCCE_EN_LSB        = 4;
   localparam int   TCCE_FLAG_LSB      = 0;
   localparam int   TCCE_FILT_LSB      = 4;
   localparam int   TCCE_SEL_W         = 2;
   localparam logic [7:0] TCCE_ENFLAG_MASK = 8'h77;
   localparam logic [7:0] TCCE_EDGE_MASK   = 8'h3f;
   localparam logic [7:0] TCCE_FILT_MASK   = 8'h70;
   localparam logic [7:0] TCCE_RST_BYTE    = 8'h00;
   localparam logic [31:0] TCCE_BAD_READ   = 32'h0000_0000;
   // Edge select codes
   localparam logic [1:0] TCCE_SEL_FALL    = 2'h0;
   localparam logic [1:0] TCCE_SEL_RISE    = 2'h1;
   localparam logic [1:0] TCCE_SEL_BOTH    = 2'h2;
   // Noise filter: input must hold this long before it is accepted
   localparam int   TCCE_CLK_PERIOD_NS = 4;
   localparam int   TCCE_FILT_TIME_NS  = 16;
   localparam int   TCCE_FILT_CYCLES   =
      (TCCE_FILT_TIME_NS + TCCE_CLK_PERIOD_NS - 1) / TCCE_CLK_PERIOD_NS;
   typedef enum logic [1:0] {TCCE_IDLE, TCCE_ACK} tcce_bus_type;
endpackage

// [rtl/tcce_filter.sv]
// Per-channel noise filter: passes a level once it has been stable long enough
module tcce_filter #(
   parameter int CYCLES = tcce_pkg::TCCE_FILT_CYCLES
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic sample_in,
   output logic      level_out
);
   import tcce_pkg::*;
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LIMIT = CW'(CYCLES);
   localparam logic [CW-1:0] ONE   = CW'(1);
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic          level_r;
   wire           differs = sample_in != level_r;
   wire           settled = differs && (count_r >= LIMIT - ONE);
   assign count_nxt = (!differs || settled) ? '0 : count_r + ONE;
   assign level_out = level_r;
   // A glitch shorter than the hold time restarts the count and is dropped
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= '0;
         level_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         if (settled) level_r <= sample_in;
      end
   end
endmodule

// [sim/tcce_assertions.sv]
// Bus and capture-path assertions for the capture edge front end
module tcce_assertions (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [2:0]  capture_in,
   input wire logic [2:0]  capture_event,
   input wire logic        irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire req = avs_read | avs_write;
   a_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest longer than one cycle");
   a_idle_nowait: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest without request");
   a_upper_zero: assert property (req && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("unused read bits set");
   a_data_held: assert property (!$past(req) |-> $stable(avs_readdata))
      else $error("read data changed without request");
   a_event_pulse: assert property ((capture_event & $past(capture_event)) == 3'h0)
      else $error("capture event longer than one cycle");
   // Eight quiet samples cover sync, filter and compare latency
   a_quiet_input: assert property ($stable(capture_in)[*8] |=> capture_event == 3'h0)
      else $error("capture event without input edge");
   a_irq_cause: assert property ($rose(irq) |-> (|capture_event) || $past(avs_write && avs_waitrequest))
      else $error("irq rose without event or write");
   a_irq_clear: assert property ($fell(irq) |-> $past(avs_write && avs_waitrequest))
      else $error("irq cleared by hardware");
   c_event0: cover property (capture_event[0]);
   c_event2: cover property (capture_event[2]);
   c_irq_drop: cover property ($fell(irq));
endmodule

bind tcce_top tcce_assertions chk (.clock, .sys_rst, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .capture_in, .capture_event, .irq);

// [sim/tcce_pin_model.sv]
// Model of the external capture pins
module tcce_pin_model (
   input  wire logic       clock,
   output logic [2:0]      capture_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial capture_in = 3'h0;
   // Pins are push-pull, so a level is simply held; changes land just after an edge
   task automatic drive(input logic [2:0] lvl, input int cyc);
      @(posedge clock);
      capture_in <= lvl;
      repeat (cyc) @(posedge clock);
   endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the capture edge front end
module tb import tcce_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FILT = 4;
   localparam logic [7:0] A_EF = TCCE_IDX_ENFLAG << 2, A_ED = TCCE_IDX_EDGE << 2;
   localparam logic [7:0] A_FL = TCCE_IDX_FILT << 2, A_ST = TCCE_IDX_IRQ_ST << 2;
   localparam logic [7:0] A_MK = TCCE_IDX_IRQ_MK << 2;
   logic        clock = 0, sys_rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [1:0]  avs_response, r;
   logic [2:0]  capture_in, capture_event;
   int          num_errors = 0, n_checks = 0, ev_cnt[3] = '{0, 0, 0};
   int          c, sel, en, filt, nar, mask, w, ev, exp, fl;
   tcce_top #(.FILT_CYCLES(FILT)) uut (.clock, .sys_rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .avs_response,
      .capture_in, .capture_event, .irq);
   tcce_pin_model pins (.clock, .capture_in);
   initial forever #2 clock = ~clock;
   always @(posedge clock)
      for (int i = 0; i < 3; i++)
         if (capture_event[i] === 1'b1)
            ev_cnt[i]++;
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int t;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      t = 0;
      do begin
         @(posedge clock);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 40);
      q = avs_readdata;
      r = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (t == 40)
         num_errors++;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      bus(1'b0, a, 8'h00);
      check(q, want);
      check({30'h0, r}, 32'h0);
   endtask
   task automatic stop_test;
      $display("Checks %0d, errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      stop_test;
   end
   initial begin
      void'($urandom(32'h12dc65fd));
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      rd(A_EF, 32'h0);
      rd(A_ED, 32'h0);
      rd(A_FL, 32'h0);
      bus(1'b0, 8'h00, 8'h00);
      check({q[7:0], r}, 10'h2);
      for (int k = 0; k < 36; k++) begin
         c = k % 3;
         sel = (k / 3) % 4;
         en = ($urandom % 4) != 0;
         filt = $urandom % 2;
         nar = filt && ($urandom % 2);
         mask = $urandom % 8;
         // A pulse shorter than the filter hold must vanish when filtering is on
         // The drive task holds a level for its count plus one cycle
         w = nar ? FILT - 2 : 2 * FILT + 1 + $urandom % 4;
         bus(1'b1, A_ED, 8'(sel << (2 * c)));
         bus(1'b1, A_FL, 8'(filt << (4 + c)));
         bus(1'b1, A_EF, 8'(en << (4 + c)));
         bus(1'b1, A_MK, 8'(mask));
         ev = ev_cnt[c];
         pins.drive(3'(1 << c), w);
         pins.drive(3'h0, 3 * FILT);
         exp = (!en || nar || sel == 3) ? 0 : (sel == 2 ? 2 : 1);
         fl = (en << (4 + c)) | ((exp > 0) << c);
         check(ev_cnt[c] - ev, exp);
         rd(A_EF, fl);
         check(irq, (exp > 0) && mask[c]);
         bus(1'b1, A_ST, 8'h07);
         check(irq, 1'b0);
         rd(A_EF, fl);
      end
      stop_test;
   end
endmodule
